// [besl_top.sv]
// module: bridge error status and latch top
`timescale 1ns/1ns
module besl_top (
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    input wire logic CE,
    input wire logic V2_MODE,
    input wire logic SUPPLY_DROP,
    input wire logic LINK_RESET,
    input wire logic ERR_VALID,
    input wire besl_pkg::besl_ev_t ERR_KIND,
    input wire logic [15:0] ERR_SLAVE_ID,
    input wire logic STATION_ERROR_CLEAR_REQUEST,
    input wire logic LAST_STATION_ERROR_CLEAR_REQUEST,
    input wire logic [4:0] RD_INDEX,
    output logic [15:0] RD_DATA,
    output logic [15:0] LATEST_ERROR_CODE_WORD,
    output logic [15:0] LATEST_ERROR_SLAVE_ID_WORD,
    output logic [9:0] LATEST_ERROR_ID_SHORT_FIELD,
    output logic SUPPLY_DROP_FLAG,
    output logic SLAVE_ALARM_FLAG,
    output logic ACCESS_FAIL_FLAG,
    output logic HOST_NOTIFY,
    output logic ALARM_LAMP,
    output logic BIT_TX_ENABLE
);
    import besl_pkg::*;
    // ****************************************
    // state
    // ****************************************
    logic [15:0] code_q;
    logic [15:0] id_q;
    logic [9:0] short_q;
    logic drop_q;
    logic alarm_q;
    logic afail_q;
    logic notify_q;
    logic lamp_q;
    logic tx_q;
    logic [15:0] rd_q;
    logic [$clog2(LAMP_CYCLES)-1:0] lamp_cnt_q;
    logic drop_seen_q;
    logic clr_any;
    logic clr_last;
    logic clr_drop;
    logic clr_grp;
    logic drop_rise;
    logic [15:0] ev_id;
    logic words_drop;
    besl_clr_if cif ();
    assign cif.any_req = STATION_ERROR_CLEAR_REQUEST |
        LAST_STATION_ERROR_CLEAR_REQUEST;
    assign cif.last_req = LAST_STATION_ERROR_CLEAR_REQUEST;
    assign clr_any = cif.clr_any;
    assign clr_last = cif.clr_last;
    besl_clr_det u_det (
        .clk(CLK_SYS),
        .rst(SYS_RST),
        .ce(CE),
        .cif(cif)
    );
    // drop state cleared by any request pulse
    assign clr_drop = clr_any;
    // group cleared by last station or link reset
    assign clr_grp = clr_last | LINK_RESET;
    assign drop_rise = SUPPLY_DROP & ~drop_seen_q;
    // target id error has no slave id
    assign ev_id = (ERR_KIND == EV_TARGET_ID) ? ID_NONE : ERR_SLAVE_ID;
    // words hold a drop entry; only such an entry yields to any request,
    // so a station pulse cannot wipe an access-group error by accident
    assign words_drop = (code_q == CODE_SUPPLY_DROP);
    // ****************************************
    // supply drop flag and transmit gate
    // ****************************************
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            drop_seen_q <= 1'b0;
            drop_q <= 1'b0;
            tx_q <= 1'b1;
        end else if (CE) begin
            drop_seen_q <= SUPPLY_DROP;
            // transmission follows the supply, no host action
            tx_q <= ~SUPPLY_DROP;
            // flag held after the drop clears; set beats clear
            if (SUPPLY_DROP) begin
                drop_q <= 1'b1;
            end else if (clr_drop) begin
                drop_q <= 1'b0;
            end
        end
    end
    // ****************************************
    // alarm flags
    // ****************************************
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            alarm_q <= 1'b0;
            afail_q <= 1'b0;
        end else if (CE) begin
            // access error to its own flag, others to alarm
            if (ERR_VALID && ERR_KIND == EV_ACCESS) begin
                afail_q <= 1'b1;
            end else if (clr_grp) begin
                // failure flag drops on a last-station clear or link reset
                afail_q <= 1'b0;
            end
            if (ERR_VALID && ERR_KIND != EV_ACCESS) begin
                alarm_q <= 1'b1;
            end else if (clr_grp) begin
                alarm_q <= 1'b0;
            end
        end
    end
    // ****************************************
    // latest error information
    // ****************************************
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            code_q <= CODE_NONE;
            id_q <= CODE_NONE;
            short_q <= '0;
            notify_q <= 1'b0;
        end else if (CE) begin
            if (drop_rise) begin
                // in v2 mode a drop stores its code with no slave id
                if (V2_MODE) begin
                    code_q <= CODE_SUPPLY_DROP;
                    id_q <= ID_NONE;
                end
            end else if (ERR_VALID) begin
                // words and notification only in v2 mode
                if (V2_MODE) begin
                    code_q <= ev_code(ERR_KIND);
                    id_q <= ev_id;
                    notify_q <= 1'b1;
                end
                // short field mirrored in any mode
                if (ERR_KIND != EV_TARGET_ID) begin
                    short_q <= ERR_SLAVE_ID[SHORT_ID_W-1:0];
                end
            end else if (clr_grp) begin
                code_q <= CODE_NONE;
                id_q <= CODE_NONE;
                short_q <= '0;
                notify_q <= 1'b0;
            end else if (clr_drop && words_drop) begin
                // drop entry cleared by any request pulse
                code_q <= CODE_NONE;
                id_q <= CODE_NONE;
            end
        end
    end
    // ****************************************
    // alarm lamp: flashes while drop flag held
    // ****************************************
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            lamp_cnt_q <= '0;
            lamp_q <= 1'b0;
        end else if (CE) begin
            // access group never touches the lamp
            if (!drop_q) begin
                lamp_cnt_q <= '0;
                lamp_q <= 1'b0;
            end else if (lamp_cnt_q ==
                    ($clog2(LAMP_CYCLES))'(LAMP_CYCLES - 1)) begin
                lamp_cnt_q <= '0;
                lamp_q <= ~lamp_q;
            end else begin
                lamp_cnt_q <= lamp_cnt_q + 1'b1;
            end
        end
    end
    // ****************************************
    // register read port
    // ****************************************
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            rd_q <= CODE_NONE;
        end else if (CE) begin
            // unmapped indices read zero
            if (RD_INDEX == REG_LATEST_CODE) begin
                rd_q <= code_q;
            end else if (RD_INDEX == REG_LATEST_ID) begin
                rd_q <= id_q;
            end else begin
                rd_q <= CODE_NONE;
            end
        end
    end
    assign RD_DATA = rd_q;
    assign LATEST_ERROR_CODE_WORD = code_q;
    assign LATEST_ERROR_SLAVE_ID_WORD = id_q;
    assign LATEST_ERROR_ID_SHORT_FIELD = short_q;
    assign SUPPLY_DROP_FLAG = drop_q;
    assign SLAVE_ALARM_FLAG = alarm_q;
    assign ACCESS_FAIL_FLAG = afail_q;
    assign HOST_NOTIFY = notify_q;
    assign ALARM_LAMP = lamp_q;
    assign BIT_TX_ENABLE = tx_q;
    // ****************************************
    // checks
    // ****************************************
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST);
    tx_follow_a: assert property (CE |=> BIT_TX_ENABLE ==
        !$past(SUPPLY_DROP)) else $error("tx not following supply");
    drop_hold_a: assert property (drop_q && !clr_drop && CE |=>
        drop_q) else $error("drop flag lost");
    drop_clr_a: assert property (CE && clr_drop && !SUPPLY_DROP |=>
        !drop_q) else $error("drop flag not cleared");
    code_new_a: assert property (CE && ERR_VALID && V2_MODE &&
        !drop_rise |=> code_q == ev_code($past(ERR_KIND)))
        else $error("wrong error code");
    v1_hold_a: assert property (CE && !V2_MODE && !clr_drop &&
        !clr_grp |=> $stable(code_q)) else $error("code moved in v1");
    afail_set_a: assert property (CE && ERR_VALID &&
        ERR_KIND == EV_ACCESS |=> afail_q) else $error("fail flag");
    alarm_set_a: assert property (CE && ERR_VALID &&
        ERR_KIND != EV_ACCESS |=> alarm_q) else $error("alarm flag");
    target_id_a: assert property (CE && ERR_VALID && V2_MODE &&
        !drop_rise && ERR_KIND == EV_TARGET_ID |=> id_q == ID_NONE)
        else $error("target id not 0FFF");
    short_mirror_a: assert property (CE && ERR_VALID && !drop_rise &&
        ERR_KIND == EV_VALUE |=> short_q == $past(ERR_SLAVE_ID[9:0]))
        else $error("short id not mirrored");
    lamp_off_a: assert property (!drop_q && CE |=> !lamp_q)
        else $error("lamp lit without drop");
    lamp_step_a: assert property (CE && drop_q && lamp_cnt_q !=
        ($clog2(LAMP_CYCLES))'(LAMP_CYCLES - 1) |=> $stable(lamp_q))
        else $error("lamp toggled early");
    ce_freeze_a: assert property (!CE |=> $stable(code_q) &&
        $stable(id_q) && $stable(drop_q) && $stable(alarm_q))
        else $error("state moved while frozen");
    rd_code_a: assert property (CE && RD_INDEX == REG_LATEST_CODE
        |=> RD_DATA == $past(code_q)) else $error("code read wrong");
    rd_id_a: assert property (CE && RD_INDEX == REG_LATEST_ID
        |=> RD_DATA == $past(id_q)) else $error("id read wrong");
    notify_v1_a: assert property (CE && !V2_MODE && !notify_q
        |=> !notify_q) else $error("notify raised in v1");
    afail_hold_a: assert property (CE && afail_q && !clr_grp
        |=> afail_q) else $error("fail flag lost");
    alarm_hold_a: assert property (CE && alarm_q && !clr_grp
        |=> alarm_q) else $error("alarm flag lost");
    grp_clr_a: assert property (CE && clr_grp && !ERR_VALID
        |=> !alarm_q && !afail_q) else $error("group not cleared");
    drop_code_a: assert property (CE && drop_rise && V2_MODE
        |=> code_q == CODE_SUPPLY_DROP && id_q == ID_NONE)
        else $error("drop words wrong");
    drop_words_a: assert property (CE && clr_drop && words_drop &&
        !ERR_VALID && !drop_rise |=> code_q == CODE_NONE)
        else $error("drop words not cleared");
    grp_keep_a: assert property (CE && clr_drop && !clr_grp &&
        !words_drop && !ERR_VALID && !drop_rise |=> $stable(code_q))
        else $error("group words cleared by station");
    short_keep_a: assert property (CE && ERR_VALID && !drop_rise &&
        ERR_KIND == EV_TARGET_ID |=> $stable(short_q))
        else $error("short field moved on target id");
    // ****************************************
    // coverage
    // ****************************************
    drop_cov: cover property (SUPPLY_DROP ##1 !SUPPLY_DROP ##[1:20] clr_drop);
    grp_cov: cover property (ERR_VALID ##[1:20] clr_grp);
    // lamp flash takes millions of cycles; short runs will not reach it
    lamp_cov: cover property (lamp_q);
    access_cov: cover property (ERR_VALID && ERR_KIND == EV_ACCESS);
    v1_cov: cover property (ERR_VALID && !V2_MODE);
endmodule // besl_top

// [besl_pkg.sv]
// package: constants and types for the bridge error status latch
package besl_pkg;
    // ****************************************
    // error codes
    // ****************************************
    localparam logic [15:0] CODE_NONE = 16'h0000;
    localparam logic [15:0] CODE_SUPPLY_DROP = 16'h00C8;
    localparam logic [15:0] CODE_HW_A = 16'h012C;
    localparam logic [15:0] CODE_HW_B = 16'h012D;
    localparam logic [15:0] CODE_TARGET_ID = 16'h012E;
    localparam logic [15:0] CODE_VALUE = 16'h012F;
    localparam logic [15:0] CODE_ACCESS = 16'h0130;
    localparam logic [15:0] CODE_STATUS = 16'h0131;
    localparam logic [15:0] CODE_DUP_ID = 16'h0190;
    localparam logic [15:0] CODE_NO_ID = 16'h0191;
    localparam logic [15:0] ID_NONE = 16'h0FFF;
    localparam logic [15:0] ID_UNSET_IN = 16'h02FF;
    localparam logic [15:0] ID_UNSET_OUT = 16'h00FF;
    // ****************************************
    // register word indices
    // ****************************************
    localparam logic [4:0] REG_LATEST_CODE = 5'h10;
    localparam logic [4:0] REG_LATEST_ID = 5'h11;
    localparam int SHORT_ID_W = 10;
    // ****************************************
    // timing: lamp toggles every 0.2 s
    // ****************************************
    localparam int CLK_HZ = 25000000;
    localparam int LAMP_PERIOD_MS = 200;
    localparam int LAMP_CYCLES = CLK_HZ / 1000 * LAMP_PERIOD_MS;
    // event kinds presented by the detection logic
    typedef enum logic [3:0] {
        EV_HW_A = 4'h0,
        EV_HW_B = 4'h1,
        EV_TARGET_ID = 4'h2,
        EV_VALUE = 4'h3,
        EV_ACCESS = 4'h4,
        EV_STATUS = 4'h5,
        EV_DUP_ID = 4'h6,
        EV_NO_ID = 4'h7
    } besl_ev_t;
    function automatic logic [15:0] ev_code(input besl_ev_t k);
        case (k)
            EV_HW_A: ev_code = CODE_HW_A;
            EV_HW_B: ev_code = CODE_HW_B;
            EV_TARGET_ID: ev_code = CODE_TARGET_ID;
            EV_VALUE: ev_code = CODE_VALUE;
            EV_ACCESS: ev_code = CODE_ACCESS;
            EV_STATUS: ev_code = CODE_STATUS;
            EV_DUP_ID: ev_code = CODE_DUP_ID;
            EV_NO_ID: ev_code = CODE_NO_ID;
            default: ev_code = CODE_NONE;
        endcase
    endfunction
endpackage

// [besl_clr_if.sv]
// interface: clear requests between top and the request detector
`timescale 1ns/1ns
interface besl_clr_if;
    logic any_req;
    logic last_req;
    logic clr_any;
    logic clr_last;
    modport det (input any_req, input last_req, output clr_any,
        output clr_last);
    modport top (output any_req, output last_req, input clr_any,
        input clr_last);
endinterface // besl_clr_if

// [besl_clr_det.sv]
// module: falling-edge detector for error reset request bits
`timescale 1ns/1ns
module besl_clr_det (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    besl_clr_if.det cif
);
    import besl_pkg::*;
    logic any_seen_q;
    logic last_seen_q;
    logic clr_any_q;
    logic clr_last_q;
    assign cif.clr_any = clr_any_q;
    assign cif.clr_last = clr_last_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            any_seen_q <= 1'b0;
            last_seen_q <= 1'b0;
            clr_any_q <= 1'b0;
            clr_last_q <= 1'b0;
        end else if (ce) begin
            any_seen_q <= cif.any_req;
            last_seen_q <= cif.last_req;
            clr_any_q <= any_seen_q & ~cif.any_req;
            clr_last_q <= last_seen_q & ~cif.last_req;
        end
    end
    clr_once_a: assert property (@(posedge clk) disable iff (rst)
        clr_any_q && ce |=> !clr_any_q) else $error("clear pulse repeated");
endmodule // besl_clr_det

// [besl_host.sv]
// partner model: host station pulsing the error reset request bits
`timescale 1ns/1ns
module besl_host #(
    parameter int HOLD = 6
) (
    input wire logic clk,
    input wire logic go_any,
    input wire logic go_last,
    output logic req_any,
    output logic req_last
);
    int cnt_any = 0;
    int cnt_last = 0;
    always @(posedge clk) begin
        if (go_any)
            cnt_any <= HOLD;
        else if (cnt_any > 0)
            cnt_any <= cnt_any - 1;
        if (go_last)
            cnt_last <= HOLD;
        else if (cnt_last > 0)
            cnt_last <= cnt_last - 1;
    end
    // a host holds each bit for whole scan cycles, never a glitch
    assign req_any = (cnt_any > 0);
    assign req_last = (cnt_last > 0);
endmodule // besl_host

// [tb_top.sv]
// testbench: error status latch checks against the host model
`timescale 1ns/1ns
module tb_top;
    import besl_pkg::*;
    typedef struct {
        besl_ev_t k;
        logic [15:0] id;
        logic [15:0] code;
        logic al;
        logic fl;
    } besl_row_t;
    logic clk, rst, ce, v2, drop, lrst, ev_v, go_any, go_last, r_any, r_last;
    besl_ev_t kind;
    logic [15:0] sid, rdat, code, id;
    logic [4:0] ridx;
    logic [9:0] shrt;
    logic dflag, alarm, fail, notify, lamp, tx;
    int n_mismatch = 0;
    int checks_done = 0;
    int cyc = 0;
    besl_row_t rows[8] = '{
        '{EV_HW_A, 16'h02FF, 16'h012C, 1'b1, 1'b0},
        '{EV_HW_B, 16'h00FF, 16'h012D, 1'b1, 1'b0},
        '{EV_TARGET_ID, 16'h0FFF, 16'h012E, 1'b1, 1'b0},
        '{EV_VALUE, 16'h0005, 16'h012F, 1'b1, 1'b0},
        '{EV_ACCESS, 16'h0021, 16'h0130, 1'b0, 1'b1},
        '{EV_STATUS, 16'h0033, 16'h0131, 1'b1, 1'b0},
        '{EV_DUP_ID, 16'h000A, 16'h0190, 1'b1, 1'b0},
        '{EV_NO_ID, 16'h02FF, 16'h0191, 1'b1, 1'b0}};
    besl_top dut_u (.CLK_SYS(clk), .SYS_RST(rst), .CE(ce), .V2_MODE(v2),
        .SUPPLY_DROP(drop), .LINK_RESET(lrst), .ERR_VALID(ev_v),
        .ERR_KIND(kind), .ERR_SLAVE_ID(sid),
        .STATION_ERROR_CLEAR_REQUEST(r_any),
        .LAST_STATION_ERROR_CLEAR_REQUEST(r_last), .RD_INDEX(ridx),
        .RD_DATA(rdat), .LATEST_ERROR_CODE_WORD(code),
        .LATEST_ERROR_SLAVE_ID_WORD(id), .LATEST_ERROR_ID_SHORT_FIELD(shrt),
        .SUPPLY_DROP_FLAG(dflag), .SLAVE_ALARM_FLAG(alarm),
        .ACCESS_FAIL_FLAG(fail), .HOST_NOTIFY(notify), .ALARM_LAMP(lamp),
        .BIT_TX_ENABLE(tx));
    besl_host host_u (.clk(clk), .go_any(go_any), .go_last(go_last),
        .req_any(r_any), .req_last(r_last));
    // ****************************************
    // helpers
    // ****************************************
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
        input string what);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %s %h want %h", $time, what,
                seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic err(input besl_ev_t k, input logic [15:0] i);
        ev_v = 1'b1;
        kind = k;
        sid = i;
        step(1);
        ev_v = 1'b0;
    endtask
    // the clear lands two cycles after the bit falls; wait past that
    task automatic pulse(input logic last);
        go_any = !last;
        go_last = last;
        step(1);
        go_any = 1'b0;
        go_last = 1'b0;
        step(12);
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_mismatch++;
            conclude();
        end
    end
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {rst, ce, v2, drop, lrst, ev_v, go_any, go_last} = 8'hE0;
        kind = EV_HW_A;
        sid = 16'h0000;
        ridx = 5'h00;
        step(2);
        rst = 1'b0;
        chk(dflag, 1'b0, "drop flag");
        chk(tx, 1'b1, "tx enable");
        chk(code, 16'h0000, "code");
        $display("reset test done");
        foreach (rows[r]) begin
            err(rows[r].k, rows[r].id);
            chk(code, rows[r].code, "code");
            chk(id, rows[r].id, "id");
            chk(shrt, (r == 2) ? 10'h000 : rows[r].id[9:0], "short");
            chk(alarm, rows[r].al, "alarm");
            chk(fail, rows[r].fl, "fail");
            chk(notify, 1'b1, "notify");
            chk(lamp, 1'b0, "lamp");
            step(3);
            chk(code, rows[r].code, "held code");
            ridx = 5'h10;
            step(1);
            chk(rdat, rows[r].code, "read code");
            ridx = 5'h11;
            step(1);
            chk(rdat, rows[r].id, "read id");
            pulse(1'b1);
            chk({code, id}, 32'h0, "cleared words");
            chk({shrt, alarm, fail, notify}, 13'h0, "cleared flags");
        end
        $display("table test done");
        ridx = 5'h12;
        step(1);
        chk(rdat, 16'h0000, "unmapped");
        ev_v = 1'b1;
        kind = EV_VALUE;
        sid = 16'h0005;
        step(1);
        kind = EV_STATUS;
        sid = 16'h0007;
        step(1);
        ev_v = 1'b0;
        chk(code, 16'h0131, "newest code");
        chk(id, 16'h0007, "newest id");
        pulse(1'b1);
        $display("back to back test done");
        err(EV_ACCESS, 16'h0021);
        pulse(1'b0);
        chk(fail, 1'b1, "fail kept");
        chk(code, 16'h0130, "code kept");
        go_last = 1'b1;
        step(1);
        go_last = 1'b0;
        step(3);
        chk(code, 16'h0130, "code during request");
        lrst = 1'b1;
        step(1);
        lrst = 1'b0;
        step(2);
        chk({fail, code}, 17'h0, "link reset");
        step(12);
        $display("clear source test done");
        v2 = 1'b0;
        err(EV_DUP_ID, 16'h000B);
        chk(code, 16'h0000, "v1 code");
        chk(notify, 1'b0, "v1 notify");
        chk(shrt, 10'h00B, "v1 short");
        v2 = 1'b1;
        pulse(1'b1);
        ce = 1'b0;
        err(EV_VALUE, 16'h0005);
        chk(code, 16'h0000, "frozen code");
        chk(shrt, 10'h000, "frozen short");
        ce = 1'b1;
        $display("mode test done");
        drop = 1'b1;
        step(2);
        chk(dflag, 1'b1, "drop flag");
        chk({code, id}, 32'h00C8_0FFF, "drop words");
        chk(tx, 1'b0, "tx stopped");
        drop = 1'b0;
        step(2);
        chk(tx, 1'b1, "tx resumed");
        chk(dflag, 1'b1, "flag kept");
        chk(code, 16'h00C8, "code kept");
        pulse(1'b0);
        chk({dflag, lamp, code}, 18'h0, "drop cleared");
        $display("supply drop test done");
        conclude();
    end
endmodule // tb_top
